// ### src/fpdc_pkg.sv
// constants for the flat panel display control block
package fpdc_pkg;
	// flat-panel extension register indices (data port reached through an index port)
	localparam logic [7:0] IDX_FRC_OPT   = 8'h16;
	localparam logic [7:0] IDX_POLY      = 8'h17;
	localparam logic [7:0] IDX_TEXT      = 8'h18;
	localparam logic [7:0] IDX_BLINK     = 8'h19;
	localparam logic [7:0] IDX_FBUF      = 8'h1A;
	localparam logic [7:0] IDX_TOGGLE    = 8'h1E;
	localparam logic [7:0] IDX_DIAG      = 8'h1F;
	localparam logic [7:0] IDX_HSIZE     = 8'h20;
	localparam logic [7:0] IDX_HSYNC     = 8'h21;
	localparam logic [7:0] IDX_HOVF      = 8'h25;
	// reset values
	localparam logic [7:0] RST_FRC_OPT   = 8'h00;
	localparam logic [7:0] RST_POLY      = 8'h00;
	localparam logic [7:0] RST_TEXT      = 8'h00;
	localparam logic [7:0] RST_BLINK     = 8'h83;
	localparam logic [7:0] RST_FBUF      = 8'h00;
	localparam logic [7:0] RST_TOGGLE    = 8'h00;
	localparam logic [7:0] RST_DIAG      = 8'h00;
	localparam logic [7:0] RST_HSIZE     = 8'h00;
	localparam logic [7:0] RST_HSYNC     = 8'h00;
	localparam logic [7:0] RST_HOVF      = 8'h00;
	// field positions
	localparam int FRC_OPT_FRAME  = 2;
	localparam int FRC_OPT_SUB    = 1;
	localparam int FRC_OPT_MAT    = 0;
	localparam int FBUF_METHOD    = 7;
	localparam int FBUF_WIRING    = 6;
	localparam int FBUF_EDO       = 2;
	localparam int FBUF_ACCEL     = 1;
	localparam int FBUF_EN        = 0;
	localparam int TOG_FRAME      = 7;
	localparam int DIAG_RING      = 3;
	localparam int DIAG_BYPCLK    = 2;
	localparam int DIAG_BYPPAL    = 1;
	localparam int DIAG_IFDIAG    = 0;
	// counts, attribute codes and text swap modes
	localparam int DOT_DIV        = 8;
	localparam int GFX_BLINK_HALF = 16;
	localparam logic [6:0] TOG_MIN = 7'h02;
	localparam logic [7:0] ATTR_NORMAL = 8'h07;
	localparam logic [7:0] ATTR_BRIGHT = 8'h0F;
	localparam logic [1:0] TXT_BOTH    = 2'h1;
	localparam logic [1:0] TXT_PANEL   = 2'h2;
endpackage : fpdc_pkg

// ### src/fpdc_flat_panel_ctrl.sv
// flat panel control: registers, dither options, blink, drive toggle, horizontal compares
`timescale 1ns/1ps
`default_nettype none
module fpdc_flat_panel_ctrl
	import fpdc_pkg::*;
#(
	parameter int HW = 12
)(
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  regIndex,
	input  wire logic [7:0]  regWrData,
	input  wire logic        regWrite,
	output logic      [7:0]  regRdData,
	input  wire logic        dotClkEn,
	input  wire logic        frameStart,
	input  wire logic        vsyncPulse,
	input  wire logic        textMode,
	input  wire logic        crtMode,
	input  wire logic        hCountClear,
	input  wire logic [7:0]  attrIn,
	input  wire logic [2:0]  internalSel0,
	input  wire logic [23:0] internalSel1,
	input  wire logic [15:0] internalSel2,
	input  wire logic [13:0] internalSel3,
	input  wire logic [20:0] normalPins,
	input  wire logic        ringOscIn,
	output logic      [7:0]  attrCrt,
	output logic      [7:0]  attrPanel,
	output logic             ditherStep,
	output logic             subMatrix2x4,
	output logic             matrix16x32,
	output logic      [3:0]  polyRowOffset,
	output logic      [3:0]  polyColOffset,
	output logic             cursorBlinkOn,
	output logic             charBlinkOn,
	output logic             pixelBlinkOn,
	output logic             externalBuffer,
	output logic             oneCasTwoWe,
	output logic             edoDram,
	output logic      [2:0]  refreshPerLine,
	output logic             frameBufferEnable,
	output logic             panelFrameStart,
	output logic             alternating_drive_output,
	output logic      [23:0] panelPins,
	output logic             activity_pin,
	output logic             clockDividerBypass,
	output logic             paletteBypass,
	output logic             panelIfDiag,
	output logic      [HW-1:0] hCount,
	output logic             hDisplayEnable,
	output logic             hSyncStart
);
	logic [7:0] frcOpt_q, poly_q, text_q, blink_q, fbuf_q, toggle_q, diag_q, hsize_q, hsync_q, hovf_q;
	logic [2:0] dotDiv_q;
	logic       dotTick, panelFrame, accelPhase_q;
	logic       frameParity_q;
	logic [5:0] cursorCnt_q;
	logic       cursorPh_q, charPh_q;
	logic [4:0] gfxCnt_q;
	logic       gfxPh_q;
	logic [7:0] togCnt_q;
	logic       togFrameDiv_q, drive_q;
	logic [HW-1:0] hCnt_q;
	logic [HW-1:0] panelSize, syncStart;
	logic       hdeQ, hsyncQ;
	logic [1:0] pinMode;
	logic       swapCrt, swapPanel;
	logic [7:0] swapped;

	// register writes through the index/data port
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			frcOpt_q <= RST_FRC_OPT;
			poly_q   <= RST_POLY;
			text_q   <= RST_TEXT;
			blink_q  <= RST_BLINK;
			fbuf_q   <= RST_FBUF;
			toggle_q <= RST_TOGGLE;
			diag_q   <= RST_DIAG;
			hsize_q  <= RST_HSIZE;
			hsync_q  <= RST_HSYNC;
			hovf_q   <= RST_HOVF;
		end
		else if (regWrite)
		begin
			unique case (regIndex)
				IDX_FRC_OPT: frcOpt_q <= regWrData;
				IDX_POLY:    poly_q   <= regWrData;
				IDX_TEXT:    text_q   <= {6'h00, regWrData[1:0]};
				IDX_BLINK:   blink_q  <= regWrData;
				IDX_FBUF:    fbuf_q   <= regWrData;
				IDX_TOGGLE:  toggle_q <= regWrData;
				IDX_DIAG:    diag_q   <= regWrData;
				IDX_HSIZE:   hsize_q  <= regWrData;
				IDX_HSYNC:   hsync_q  <= regWrData;
				IDX_HOVF:    hovf_q   <= regWrData;
				default:     ;
			endcase
		end
	end

	always_comb
	begin
		unique case (regIndex)
			IDX_FRC_OPT: regRdData = frcOpt_q;
			IDX_POLY:    regRdData = poly_q;
			IDX_TEXT:    regRdData = text_q;
			IDX_BLINK:   regRdData = blink_q;
			IDX_FBUF:    regRdData = fbuf_q;
			IDX_TOGGLE:  regRdData = toggle_q;
			IDX_DIAG:    regRdData = diag_q;
			IDX_HSIZE:   regRdData = hsize_q;
			IDX_HSYNC:   regRdData = hsync_q;
			IDX_HOVF:    regRdData = hovf_q;
			default:     regRdData = 8'h00;
		endcase
	end

	// dither options
	assign subMatrix2x4  = frcOpt_q[FRC_OPT_SUB];
	assign matrix16x32   = frcOpt_q[FRC_OPT_MAT];
	assign polyRowOffset = poly_q[7:4];
	assign polyColOffset = poly_q[3:0];

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			frameParity_q <= 1'b0;
		else if (frameStart)
			frameParity_q <= ~frameParity_q;
	end
	// dither advances every frame, or only on even frames
	assign ditherStep = frameStart & (~frcOpt_q[FRC_OPT_FRAME] | frameParity_q);

	// text attribute swap
	assign swapCrt   = text_q[1:0] == TXT_BOTH;
	assign swapPanel = (text_q[1:0] == TXT_BOTH) | (text_q[1:0] == TXT_PANEL);
	assign swapped   = (attrIn == ATTR_NORMAL) ? ATTR_BRIGHT :
	                   (attrIn == ATTR_BRIGHT) ? ATTR_NORMAL : attrIn;
	assign attrCrt   = swapCrt ? swapped : attrIn;
	assign attrPanel = swapPanel ? swapped : attrIn;

	// cursor blink: toggles every (field+1) vsyncs
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cursorCnt_q <= 6'h00;
			cursorPh_q  <= 1'b0;
			charPh_q    <= 1'b0;
		end
		else if (vsyncPulse)
		begin
			if (cursorCnt_q >= blink_q[5:0])
			begin
				cursorCnt_q <= 6'h00;
				cursorPh_q  <= ~cursorPh_q;
				if (cursorPh_q)
					charPh_q <= ~charPh_q;
			end
			else
				cursorCnt_q <= cursorCnt_q + 6'h01;
		end
	end
	assign cursorBlinkOn = ~cursorPh_q;

	// char blink over a two-cursor-period cycle: quarters from {charPh,cursorPh}
	always_comb
	begin
		unique case (blink_q[7:6])
			2'b00:   charBlinkOn = ~cursorPh_q;
			2'b01:   charBlinkOn = ~charPh_q & ~cursorPh_q;
			2'b10:   charBlinkOn = ~charPh_q;
			default: charBlinkOn = ~(charPh_q & cursorPh_q);
		endcase
	end

	// graphics pixel blink, fixed
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			gfxCnt_q <= 5'h00;
			gfxPh_q  <= 1'b0;
		end
		else if (vsyncPulse)
		begin
			if (gfxCnt_q == 5'(GFX_BLINK_HALF - 1))
			begin
				gfxCnt_q <= 5'h00;
				gfxPh_q  <= ~gfxPh_q;
			end
			else
				gfxCnt_q <= gfxCnt_q + 5'h01;
		end
	end
	assign pixelBlinkOn = ~gfxPh_q;

	// frame buffer selection
	assign externalBuffer    = fbuf_q[FBUF_METHOD];
	assign oneCasTwoWe       = externalBuffer & fbuf_q[FBUF_WIRING];
	assign edoDram           = externalBuffer & fbuf_q[FBUF_EDO];
	assign refreshPerLine    = externalBuffer ? fbuf_q[5:3] : 3'h0;
	assign frameBufferEnable = fbuf_q[FBUF_EN];

	// accelerator: an extra panel frame at mid-frame of each crt frame
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			accelPhase_q <= 1'b0;
		else if (frameStart)
			accelPhase_q <= 1'b0;
		else if (vsyncPulse)
			accelPhase_q <= 1'b1;
	end
	assign panelFrame      = frameStart | (fbuf_q[FBUF_ACCEL] & vsyncPulse & ~accelPhase_q);
	assign panelFrameStart = panelFrame;

	// alternating drive output
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			togCnt_q      <= 8'h00;
			togFrameDiv_q <= 1'b0;
			drive_q       <= 1'b0;
		end
		else if (toggle_q[TOG_FRAME])
		begin
			togCnt_q <= 8'h00;
			if (panelFrame)
			begin
				togFrameDiv_q <= ~togFrameDiv_q;
				if (!fbuf_q[FBUF_ACCEL] || togFrameDiv_q)
					drive_q <= ~drive_q;
			end
		end
		else if (hSyncStart && toggle_q[6:0] > TOG_MIN)
		begin
			// one bit wider than the field so the largest count cannot wrap
			if (togCnt_q >= {1'b0, toggle_q[6:0]} + 8'h01)
			begin
				togCnt_q <= 8'h00;
				drive_q  <= ~drive_q;
			end
			else
				togCnt_q <= togCnt_q + 8'h01;
		end
	end

	// horizontal counter on dot clock / 8
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			dotDiv_q <= 3'h0;
		else if (dotClkEn)
			dotDiv_q <= dotDiv_q + 3'h1;
	end
	assign dotTick = dotClkEn & ((dotDiv_q == 3'(DOT_DIV - 1)) | diag_q[DIAG_BYPCLK]);

	assign panelSize = HW'({hovf_q[3:0], hsize_q});
	assign syncStart = HW'({hovf_q[7:4], hsync_q});

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hCnt_q <= '0;
			hdeQ   <= 1'b1;
			hsyncQ <= 1'b0;
		end
		else if (hCountClear)
		begin
			hCnt_q <= '0;
			hdeQ   <= 1'b1;
			hsyncQ <= 1'b0;
		end
		else if (dotTick)
		begin
			hCnt_q <= hCnt_q + HW'(1);
			if (hCnt_q == panelSize)
				hdeQ <= 1'b0;
			hsyncQ <= ~crtMode && (hCnt_q == syncStart);
		end
		else
			hsyncQ <= 1'b0;
	end
	assign hCount         = hCnt_q;
	assign hDisplayEnable = hdeQ;
	assign hSyncStart     = hsyncQ;

	// diagnostic pin routing
	assign pinMode = diag_q[5:4];
	always_comb
	begin
		unique case (pinMode)
			2'b00:   panelPins = {3'h0, normalPins};
			2'b01:   panelPins = internalSel1 ^ {21'h0, internalSel0};
			2'b10:   panelPins = {8'h00, internalSel2};
			default: panelPins = {10'h000, internalSel3};
		endcase
	end
	assign alternating_drive_output = drive_q;
	assign activity_pin       = diag_q[DIAG_RING] & ringOscIn;
	assign clockDividerBypass = diag_q[DIAG_BYPCLK];
	assign paletteBypass      = diag_q[DIAG_BYPPAL];
	assign panelIfDiag        = diag_q[DIAG_IFDIAG];

	// assertions
	a_cursor_reset_val: assert property (@(posedge core_clk) $rose(rst_n) |-> blink_q == RST_BLINK)
		else $error("blink register reset value wrong");
	a_ext_only_edo: assert property (@(posedge core_clk) disable iff (!rst_n)
		!fbuf_q[FBUF_METHOD] |-> !edoDram && !oneCasTwoWe && refreshPerLine == 3'h0)
		else $error("external-only bits active with embedded buffer");
	a_dither_alt: assert property (@(posedge core_clk) disable iff (!rst_n)
		frcOpt_q[FRC_OPT_FRAME] && frameStart && !frameParity_q |-> !ditherStep)
		else $error("dither stepped on odd frame");
	a_hde_end: assert property (@(posedge core_clk) disable iff (!rst_n)
		dotTick && !hCountClear && hCnt_q == panelSize |=> !hDisplayEnable)
		else $error("display enable not ended at panel size");
	a_hsync_start: assert property (@(posedge core_clk) disable iff (!rst_n)
		dotTick && !hCountClear && !crtMode && hCnt_q == syncStart |=> hSyncStart)
		else $error("sync start missed");
	a_gfx_blink: assert property (@(posedge core_clk) disable iff (!rst_n)
		$changed(gfxPh_q) |-> $past(gfxCnt_q) == 5'(GFX_BLINK_HALF - 1))
		else $error("graphics blink half period wrong");
	a_swap_panel: assert property (@(posedge core_clk) disable iff (!rst_n)
		text_q[1:0] == TXT_PANEL && attrIn == ATTR_NORMAL |-> attrPanel == ATTR_BRIGHT && attrCrt == ATTR_NORMAL)
		else $error("panel-only swap wrong");
	a_diag_normal: assert property (@(posedge core_clk) disable iff (!rst_n)
		diag_q[5:4] == 2'b00 |-> panelPins[20:0] == normalPins)
		else $error("pins not in normal mode");
	a_drive_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
		!toggle_q[TOG_FRAME] && !$past(toggle_q[TOG_FRAME])
		&& toggle_q[6:0] <= TOG_MIN && $past(toggle_q[6:0]) <= TOG_MIN
		|-> $stable(drive_q))
		else $error("drive toggled with count not above two");
	a_drive_count: assert property (@(posedge core_clk) disable iff (!rst_n)
		$changed(drive_q) && !$past(toggle_q[TOG_FRAME]) |-> $past(togCnt_q) >= {1'b0, $past(toggle_q[6:0])} + 8'h01)
		else $error("drive toggled before hsync count reached");
	a_frame_toggle: assert property (@(posedge core_clk) disable iff (!rst_n)
		toggle_q[TOG_FRAME] && !fbuf_q[FBUF_ACCEL] && panelFrame |=> drive_q != $past(drive_q))
		else $error("drive missed a frame toggle");
endmodule : fpdc_flat_panel_ctrl
`default_nettype wire

// ### tb/fpdc_panel_model.sv
// behavioural panel side: paced dot clock ticks with a tick counter
`timescale 1ns/1ps
`default_nettype none
module fpdc_panel_model (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       run,
	output logic            dotClkEn,
	output logic [7:0]      dotCount
);
	logic phase_q;
	// dot clock at half the core rate, stands still while not running
	assign dotClkEn = run & phase_q;
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			phase_q  <= 1'b0;
			dotCount <= 8'h00;
		end
		else
		begin
			phase_q  <= ~phase_q;
			dotCount <= run ? dotCount + {7'h00, dotClkEn} : 8'h00;
		end
	end
endmodule : fpdc_panel_model
`default_nettype wire

// ### tb/tb_fpdc_flat_panel_ctrl.sv
// self-checking bench for the flat panel control block
`timescale 1ns/1ps
`default_nettype none
module tb_fpdc_flat_panel_ctrl;
	import fpdc_pkg::*;
	logic        core_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  regIndex = 8'h00;
	logic [7:0]  regWrData = 8'h00;
	logic        regWrite = 1'b0;
	logic        frameStart = 1'b0;
	logic        vsyncPulse = 1'b0;
	logic        textMode = 1'b1;
	logic        crtMode = 1'b0;
	logic        hCountClear = 1'b0;
	logic [7:0]  attrIn = 8'h07;
	logic        ringOscIn = 1'b0;
	logic [20:0] normalPins = 21'h1ABCDE;
	logic [2:0]  internalSel0 = 3'h5;
	logic [23:0] internalSel1 = 24'hC3A501;
	logic [15:0] internalSel2 = 16'hBEEF;
	logic [13:0] internalSel3 = 14'h2D2D;
	logic        dotRun = 1'b0;
	logic        dotClkEn;
	logic [7:0]  dotCount;
	logic [7:0]  regRdData, attrCrt, attrPanel;
	logic [3:0]  polyRowOffset, polyColOffset;
	logic [2:0]  refreshPerLine;
	logic [23:0] panelPins;
	logic [11:0] hCount;
	logic        ditherStep, subMatrix2x4, matrix16x32, cursorBlinkOn, charBlinkOn, pixelBlinkOn;
	logic        externalBuffer, oneCasTwoWe, edoDram, frameBufferEnable, panelFrameStart;
	logic        alternating_drive_output, activity_pin, clockDividerBypass, paletteBypass, panelIfDiag;
	logic        hDisplayEnable, hSyncStart;
	int          fail_count = 0;
	int          tests_run = 0;
	int          cycles = 0;
	int          ditherCount = 0;

	fpdc_panel_model u_panel (.core_clk, .rst_n, .run(dotRun), .dotClkEn, .dotCount);
	fpdc_flat_panel_ctrl #(.HW(12)) u_dut (
		.core_clk, .rst_n, .regIndex, .regWrData, .regWrite, .regRdData, .dotClkEn, .frameStart,
		.vsyncPulse, .textMode, .crtMode, .hCountClear, .attrIn, .internalSel0,
		.internalSel1, .internalSel2, .internalSel3,
		.normalPins, .ringOscIn, .attrCrt, .attrPanel, .ditherStep, .subMatrix2x4,
		.matrix16x32, .polyRowOffset, .polyColOffset, .cursorBlinkOn, .charBlinkOn, .pixelBlinkOn,
		.externalBuffer, .oneCasTwoWe, .edoDram, .refreshPerLine, .frameBufferEnable, .panelFrameStart,
		.alternating_drive_output, .panelPins, .activity_pin, .clockDividerBypass, .paletteBypass,
		.panelIfDiag, .hCount, .hDisplayEnable, .hSyncStart);

	always #10 core_clk = ~core_clk;

	always @(posedge core_clk)
	begin
		cycles++;
		ditherCount += (ditherStep === 1'b1);
		if (cycles == 20000)
		begin
			fail_count++;
			test_done();
		end
	end

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : test_done

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("ERROR t=%0t seen=%0h expected=%0h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		@(posedge core_clk);
		#1;
		regIndex = idx;
		regWrData = d;
		regWrite = 1'b1;
		@(posedge core_clk);
		#1;
		regWrite = 1'b0;
	endtask : wr

	task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
		regIndex = idx;
		@(posedge core_clk);
		#1;
		check(regRdData, exp);
	endtask : rdc

	task automatic pulse(ref logic s);
		@(posedge core_clk);
		#1;
		s = 1'b1;
		@(posedge core_clk);
		#1;
		s = 1'b0;
		@(posedge core_clk);
		#1;
	endtask : pulse

	// run the dot clock for n ticks, counting sync pulses
	task automatic run(input int n, inout int s);
		dotRun = 1'b1;
		while (dotCount != 8'(n))
		begin
			@(posedge core_clk);
			#1;
			s += (hSyncStart === 1'b1);
		end
		dotRun = 1'b0;
		@(posedge core_clk);
		#1;
		s += (hSyncStart === 1'b1);
	endtask : run

	task automatic vs(input int n, output int cur, output int pix, output int on);
		logic c;
		logic p;
		cur = 0;
		pix = 0;
		on = 0;
		for (int i = 0; i < n; i++)
		begin
			c = cursorBlinkOn;
			p = pixelBlinkOn;
			pulse(vsyncPulse);
			cur += (cursorBlinkOn !== c);
			pix += (pixelBlinkOn !== p);
			on += (charBlinkOn === 1'b1);
		end
	endtask : vs

	task automatic t_regs();
		logic [7:0] idx [10] = '{IDX_FRC_OPT, IDX_POLY, IDX_TEXT, IDX_BLINK, IDX_FBUF,
			IDX_TOGGLE, IDX_DIAG, IDX_HSIZE, IDX_HSYNC, IDX_HOVF};
		logic [7:0] rv [10] = '{RST_FRC_OPT, RST_POLY, RST_TEXT, RST_BLINK, RST_FBUF,
			RST_TOGGLE, RST_DIAG, RST_HSIZE, RST_HSYNC, RST_HOVF};
		// mode 01 folds the three control bits onto the low pins
		logic [23:0] pinsExp [4] = '{24'h1ABCDE, 24'hC3A504, 24'h00BEEF, 24'h002D2D};
		for (int i = 0; i < 10; i++)
			rdc(idx[i], rv[i]);
		wr(8'h22, 8'h5A);
		rdc(8'h22, 8'h00);
		wr(IDX_FRC_OPT, 8'h03);
		check({subMatrix2x4, matrix16x32}, 2'h3);
		wr(IDX_FRC_OPT, 8'h01);
		check({subMatrix2x4, matrix16x32}, 2'h1);
		wr(IDX_POLY, 8'hA5);
		check({polyRowOffset, polyColOffset}, 8'hA5);
		wr(IDX_FBUF, 8'h7C);
		check({externalBuffer, oneCasTwoWe, edoDram, refreshPerLine}, 6'h00);
		wr(IDX_FBUF, 8'hFD);
		check({externalBuffer, oneCasTwoWe, edoDram, refreshPerLine, frameBufferEnable}, 7'h7F);
		rdc(IDX_FBUF, 8'hFD);
		ringOscIn = 1'b1;
		wr(IDX_DIAG, 8'h0F);
		check({activity_pin, clockDividerBypass, paletteBypass, panelIfDiag}, 4'hF);
		ringOscIn = 1'b0;
		#1;
		check(activity_pin, 1'b0);
		wr(IDX_DIAG, 8'h00);
		check({clockDividerBypass, paletteBypass}, 2'h0);
		for (int p = 0; p < 4; p++)
		begin
			wr(IDX_DIAG, 8'(p << 4));
			check(panelPins, pinsExp[p]);
		end
		wr(IDX_DIAG, 8'h00);
		normalPins = 21'h054321;
		#1;
		check(panelPins, 24'h054321);
		wr(IDX_TEXT, 8'hFE);
		rdc(IDX_TEXT, 8'h02);
		for (int c = 0; c < 3; c++)
		begin
			wr(IDX_TEXT, 8'(c));
			attrIn = ATTR_NORMAL;
			#1;
			check(attrCrt, (c == 1) ? ATTR_BRIGHT : ATTR_NORMAL);
			check(attrPanel, (c == 0) ? ATTR_NORMAL : ATTR_BRIGHT);
		end
		wr(IDX_FBUF, 8'h00);
		for (int o = 0; o < 2; o++)
		begin
			wr(IDX_FRC_OPT, 8'(o << 2));
			ditherCount = 0;
			repeat (4) pulse(frameStart);
			check(ditherCount, 4 >> o);
		end
	endtask : t_regs

	task automatic t_blink();
		int cur;
		int pix;
		int on;
		int onExp [4] = '{8, 4, 8, 12};
		for (int k = 0; k < 4; k++)
		begin
			wr(IDX_BLINK, 8'(k << 6));
			vs(16, cur, pix, on);
			check(cur, 16);
			check(on, onExp[k]);
		end
		wr(IDX_BLINK, 8'h01);
		vs(16, cur, pix, on);
		check(cur, 8);
		textMode = 1'b0;
		vs(32, cur, pix, on);
		check(pix, 2);
		textMode = 1'b1;
	endtask : t_blink

	// frame toggle, frame toggle with accelerator, count mode below its minimum
	task automatic t_drive();
		int n;
		logic d;
		for (int m = 0; m < 3; m++)
		begin
			wr(IDX_FBUF, (m == 1) ? 8'h03 : 8'h01);
			wr(IDX_TOGGLE, (m == 2) ? 8'h00 : 8'h80);
			n = 0;
			repeat (4)
			begin
				d = alternating_drive_output;
				pulse(frameStart);
				pulse(vsyncPulse);
				n += (alternating_drive_output !== d);
			end
			check(n, (m == 2) ? 0 : 4);
		end
	endtask : t_drive

	task automatic t_horiz();
		int s;
		int n;
		logic d;
		logic [11:0] h0;
		wr(IDX_HSIZE, 8'h03);
		wr(IDX_HSYNC, 8'h01);
		wr(IDX_HOVF, 8'h00);
		for (int c = 0; c < 2; c++)
		begin
			crtMode = c[0];
			s = 0;
			pulse(hCountClear);
			run(8, s);
			h0 = hCount;
			check(hDisplayEnable, 1'b1);
			run(40, s);
			check(12'(hCount - h0), 12'h005);
			check(hDisplayEnable, 1'b0);
			check(s, 1 - c);
		end
		crtMode = 1'b0;
		wr(IDX_DIAG, 8'h04);
		pulse(hCountClear);
		run(8, s);
		check(hCount, 12'h008);
		// count mode: programmed 3 means a phase change every 5 lines
		wr(IDX_TOGGLE, 8'h03);
		n = 0;
		for (int i = 1; i <= 10; i++)
		begin
			d = alternating_drive_output;
			pulse(hCountClear);
			run(4, s);
			n += (alternating_drive_output !== d);
			check(n, i / 5);
		end
		wr(IDX_TOGGLE, 8'h00);
		wr(IDX_DIAG, 8'h00);
	endtask : t_horiz

	initial
	begin
		repeat (16) @(posedge core_clk);
		#1;
		rst_n = 1'b1;
		t_regs();
		t_blink();
		t_drive();
		t_horiz();
		test_done();
	end
endmodule : tb_fpdc_flat_panel_ctrl
`default_nettype wire
